// File: rtl/parallel_control_port.sv
// eight-bit parallel host port with wishbone status, mask and control
// Overview of operation
// [RULE_01] open-drain low alert on enabled status
// [RULE_02] legacy select forces test reset low
// [RULE_03] float input releases every driven pin
// [RULE_04] multiplex select picks bus addressing style
// [RULE_05] shared lines: data only, or address/data
// [RULE_06] non-multiplexed address from seven lower lines
// [RULE_07] top bit, or address latched on rise
// [RULE_08] style strap remaps read, latch, write pins; the code remaps only the read and write pins, the latch pin is unchanged
// [RULE_09] read strobe times reads, or data strobe
// [RULE_10] chip select high ignores all strobes
// [RULE_11] write strobe stores, or direction line
//
// The Wishbone slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module parallel_control_port #(
   parameter int ADDR_W = pcp_pkg::ADDR_W,
   parameter int DATA_W = pcp_pkg::DATA_W,
   parameter int EVT_W = pcp_pkg::EXT_EVT_W
) (
   input wire logic SYS_CLK,
   input wire logic RST_B,
   // asynchronous host pins and straps
   input wire pcp_pkg::host_pins_s HOST_PINS_I,
   input wire pcp_pkg::straps_s STRAPS_I,
   output logic [DATA_W-1:0] AD_O,
   output logic AD_OE_N,
   output logic HOST_INT_O,
   output logic HOST_INT_OE_N,
   output logic TEST_RST_N_O,
   output logic LEGACY_MODE_O,
   // device events on SYS_CLK, one-cycle pulses
   input wire logic [EVT_W-1:0] EVENT_I,
   // classic wishbone slave
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O
);
   pcp_pkg::host_pins_s p;
   pcp_pkg::host_pins_s p_q;
   pcp_pkg::straps_s s;
   logic [7:0] status_q;
   logic [7:0] mask_q;
   logic [7:0] ctrl_q;
   logic [ADDR_W-1:0] addr_latch_q;
   logic [ADDR_W-1:0] addr_cur;
   logic [ADDR_W-1:0] addr_hold_q;
   logic [DATA_W-1:0] data_hold_q;
   logic [DATA_W-1:0] rdata;
   logic sel;
   logic rd_act;
   logic wr_act;
   logic rd_act_q;
   logic wr_act_q;
   logic store_we;
   logic ale_rise;
   logic wb_req;
   logic wb_wr;
   logic wb_wr_status;
   logic [7:0] evt_set;

   // every pin crosses two flops before any logic sees it
   pin_sync #(.W($bits(pcp_pkg::host_pins_s)), .INIT(pcp_pkg::PINS_IDLE)) u_pin_sync (
      .clk(SYS_CLK),
      .rst_b(RST_B),
      .d(HOST_PINS_I),
      .q(p)
   );

   pin_sync #(.W($bits(pcp_pkg::straps_s)), .INIT(pcp_pkg::STRAPS_IDLE)) u_strap_sync (
      .clk(SYS_CLK),
      .rst_b(RST_B),
      .d(STRAPS_I),
      .q(s)
   );

   // previous synced sample, for edge detection
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         p_q <= pcp_pkg::PINS_IDLE;
      end else begin
         p_q <= p;
      end
   end

   // strobe decode; the style strap remaps the read and write pins
   always_comb begin
      sel = !p.cs_n && ctrl_q[pcp_pkg::CTRL_PORT_EN]; // [RULE_10]
      if (s.bus_style_select) begin
         // data strobe on the read pin, direction on the write pin
         rd_act = sel && !p.rd_n && p.wr_n; // [RULE_08] [RULE_09] [RULE_11]
         wr_act = sel && !p.rd_n && !p.wr_n; // [RULE_11]
      end else begin
         rd_act = sel && !p.rd_n; // [RULE_09]
         wr_act = sel && !p.wr_n && p.rd_n; // [RULE_11]
      end
   end

   // address source follows the multiplex select
   always_comb begin
      ale_rise = p.ale && !p_q.ale;
      if (s.bus_multiplex_select) begin
         addr_cur = addr_latch_q; // [RULE_04] [RULE_06]
      end else begin
         addr_cur = {p.ale, p.addr_lo}; // [RULE_06] [RULE_07]
      end
   end

   // in multiplexed mode the shared lines carry the address at the latch rise
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         addr_latch_q <= '0;
      end else if (s.bus_multiplex_select && ale_rise) begin
         addr_latch_q <= p.ad; // [RULE_05] [RULE_07]
      end
   end

   // hold address and data while the write strobe is active; commit at its end
   // so that data which settles late in the strobe is still caught
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         wr_act_q <= 1'b0;
         rd_act_q <= 1'b0;
         addr_hold_q <= '0;
         data_hold_q <= '0;
      end else begin
         wr_act_q <= wr_act;
         rd_act_q <= rd_act;
         if (wr_act) begin
            addr_hold_q <= addr_cur;
            data_hold_q <= p.ad; // [RULE_05]
         end
      end
   end

   assign store_we = wr_act_q && !wr_act; // [RULE_11]

   reg_store #(.AW(ADDR_W), .DW(DATA_W)) u_store (
      .clk(SYS_CLK),
      .we(store_we),
      .waddr(addr_hold_q),
      .wdata(data_hold_q),
      .raddr(addr_cur),
      .rdata_q(rdata)
   );

   // read drive: lines driven only during a read strobe and never while floating;
   // data lags the address by two cycles: the store's one-cycle read latency plus the output register
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         AD_O <= '0;
         AD_OE_N <= 1'b1;
      end else begin
         AD_O <= rdata;
         AD_OE_N <= !(rd_act && rd_act_q) || s.float_all; // [RULE_03] [RULE_09]
      end
   end

   // test reset pass-through, forced low in legacy mode
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         TEST_RST_N_O <= 1'b0;
         LEGACY_MODE_O <= 1'b0;
      end else begin
         TEST_RST_N_O <= s.trst_n && !s.legacy; // [RULE_02]
         LEGACY_MODE_O <= s.legacy; // [RULE_02]
      end
   end

   // event sources: port activity plus device conditions
   always_comb begin
      evt_set = '0;
      evt_set[pcp_pkg::ST_HOST_WR] = store_we;
      evt_set[pcp_pkg::ST_HOST_RD] = rd_act && !rd_act_q;
      evt_set[pcp_pkg::ST_ADDR_LATCH] = s.bus_multiplex_select && ale_rise;
      evt_set[pcp_pkg::ST_EXT_LSB +: EVT_W] = EVENT_I;
   end

   assign wb_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
   // writes land at the edge where the master sees ack, while it still holds the request
   assign wb_wr = WB_CYC_I && WB_STB_I && WB_ACK_O && WB_WE_I && WB_SEL_I[0];
   assign wb_wr_status = wb_wr && (WB_ADR_I == pcp_pkg::OFS_STATUS);

   // sticky status, write one to clear; a new event wins over the clear
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         status_q <= pcp_pkg::STATUS_RST;
      end else if (wb_wr_status) begin
         status_q <= (status_q & ~WB_DAT_I[7:0]) | evt_set;
      end else begin
         status_q <= status_q | evt_set; // [RULE_01]
      end
   end

   // mask and control writes
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         mask_q <= pcp_pkg::MASK_RST;
         ctrl_q <= pcp_pkg::CTRL_RST;
      end else if (wb_wr) begin
         if (WB_ADR_I == pcp_pkg::OFS_MASK) begin
            mask_q <= WB_DAT_I[7:0];
         end
         if (WB_ADR_I == pcp_pkg::OFS_CTRL) begin
            ctrl_q <= WB_DAT_I[7:0];
         end
      end
   end

   // single-cycle ack; unmapped reads return zero, writes are dropped
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= '0;
      end else begin
         WB_ACK_O <= wb_req;
         WB_DAT_O <= '0;
         if (wb_req && !WB_WE_I) begin
            case (WB_ADR_I)
               pcp_pkg::OFS_STATUS: WB_DAT_O[7:0] <= status_q;
               pcp_pkg::OFS_MASK: WB_DAT_O[7:0] <= mask_q;
               pcp_pkg::OFS_CTRL: WB_DAT_O[7:0] <= ctrl_q;
               pcp_pkg::OFS_STATE: begin
                  WB_DAT_O[4:0] <= s;
                  WB_DAT_O[pcp_pkg::STATE_ADDR_LSB +: ADDR_W] <= addr_hold_q;
               end
               default: WB_DAT_O <= '0;
            endcase
         end
      end
   end

   // open-drain alert: output value always low, enable pulls the wire
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         HOST_INT_O <= 1'b0;
         HOST_INT_OE_N <= 1'b1;
      end else begin
         HOST_INT_O <= 1'b0;
         HOST_INT_OE_N <= !(|(status_q & mask_q)) || s.float_all; // [RULE_01] [RULE_03]
      end
   end

   // checks
   a_float_ad_off: assert property ( // [RULE_03]
      @(posedge SYS_CLK) disable iff (!RST_B) s.float_all |=> AD_OE_N)
      else $error("data lines driven while floating");

   a_float_int_off: assert property ( // [RULE_03]
      @(posedge SYS_CLK) disable iff (!RST_B) s.float_all |=> HOST_INT_OE_N)
      else $error("alert driven while floating");

   a_legacy_trst_low: assert property ( // [RULE_02]
      @(posedge SYS_CLK) disable iff (!RST_B) s.legacy |=> !TEST_RST_N_O && LEGACY_MODE_O)
      else $error("test reset not held");

   a_alert_follows_mask: assert property ( // [RULE_01]
      @(posedge SYS_CLK) disable iff (!RST_B)
      (|(status_q & mask_q)) && !s.float_all |=> !HOST_INT_OE_N && !HOST_INT_O)
      else $error("enabled status without alert");

   a_cs_blocks_store: assert property ( // [RULE_10]
      @(posedge SYS_CLK) disable iff (!RST_B) p.cs_n[*2] |-> !store_we && !rd_act)
      else $error("strobe honoured without select");

   a_mux_latch_addr: assert property ( // [RULE_07]
      @(posedge SYS_CLK) disable iff (!RST_B)
      s.bus_multiplex_select && p.ale && !p_q.ale |=> addr_latch_q == $past(p.ad))
      else $error("address not latched on rise");

   a_nonmux_write_addr: assert property ( // [RULE_06]
      @(posedge SYS_CLK) disable iff (!RST_B)
      !s.bus_multiplex_select && wr_act ##1 !wr_act |-> addr_hold_q == {$past(p.ale), $past(p.addr_lo)})
      else $error("wrong non-multiplexed write address");

   a_ds_dir_read: assert property ( // [RULE_08]
      @(posedge SYS_CLK) disable iff (!RST_B)
      s.bus_style_select && sel && !p.rd_n && p.wr_n ##1
      s.bus_style_select && sel && !p.rd_n && p.wr_n && !s.float_all |=> !AD_OE_N)
      else $error("data strobe read not driven");

   a_status_sticky: assert property ( // [RULE_01]
      @(posedge SYS_CLK) disable iff (!RST_B)
      status_q[pcp_pkg::ST_HOST_WR] && !wb_wr_status |=> status_q[pcp_pkg::ST_HOST_WR])
      else $error("status bit lost");

   a_wb_ack_once: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
      WB_ACK_O |=> !WB_ACK_O) else $error("ack held two cycles");

   c_host_write: cover property (@(posedge SYS_CLK) disable iff (!RST_B) store_we);
   c_mux_read: cover property (@(posedge SYS_CLK) disable iff (!RST_B)
      s.bus_multiplex_select && rd_act && rd_act_q);
   c_alert: cover property (@(posedge SYS_CLK) disable iff (!RST_B) !HOST_INT_OE_N);
   c_set_and_clear: cover property (@(posedge SYS_CLK) disable iff (!RST_B)
      wb_wr_status && |evt_set);
endmodule
`default_nettype wire

// File: shared/pcp_pkg.sv
// shared constants and carrier types for the parallel control port
package pcp_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int LOW_ADDR_W = 7;
   localparam int EXT_EVT_W = 5;
   // wishbone register byte offsets
   localparam logic [7:0] OFS_STATUS = 8'h00;
   localparam logic [7:0] OFS_MASK = 8'h04;
   localparam logic [7:0] OFS_CTRL = 8'h08;
   localparam logic [7:0] OFS_STATE = 8'h0C;
   // status and mask bit positions
   localparam int ST_HOST_WR = 0;
   localparam int ST_HOST_RD = 1;
   localparam int ST_ADDR_LATCH = 2;
   localparam int ST_EXT_LSB = 3;
   // control register fields and reset values
   localparam int CTRL_PORT_EN = 0;
   localparam logic [7:0] CTRL_RST = 8'h01;
   localparam logic [7:0] MASK_RST = 8'h00;
   localparam logic [7:0] STATUS_RST = 8'h00;
   // state register field positions
   localparam int STATE_ADDR_LSB = 8;

   typedef struct packed {
      logic cs_n;
      logic rd_n;
      logic wr_n;
      logic ale;
      logic [LOW_ADDR_W-1:0] addr_lo;
      logic [DATA_W-1:0] ad;
   } host_pins_s;

   typedef struct packed {
      logic bus_multiplex_select;
      logic bus_style_select;
      logic legacy;
      logic float_all;
      logic trst_n;
   } straps_s;

   // idle level of the host pins: strobes and select high
   localparam host_pins_s PINS_IDLE = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, ale: 1'b0,
      addr_lo: 7'h00, ad: 8'h00};
   localparam straps_s STRAPS_IDLE = '{bus_multiplex_select: 1'b0, bus_style_select: 1'b0, legacy: 1'b0,
      float_all: 1'b0, trst_n: 1'b1};
endpackage

// File: rtl/pin_sync.sv
// two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   // first stage feeds only the second stage
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_q <= INIT;
         q <= INIT;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule
`default_nettype wire

// File: rtl/reg_store.sv
// internal register space reached by the host, registered read data
`timescale 1ns/1ps
`default_nettype none
module reg_store #(
   parameter int AW = 8,
   parameter int DW = 8
) (
   input wire logic clk,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [DW-1:0] wdata,
   input wire logic [AW-1:0] raddr,
   output logic [DW-1:0] rdata_q
);
   logic [DW-1:0] mem [0:(1<<AW)-1];

   // no reset: contents are undefined until the host writes them
   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata_q <= mem[raddr];
   end
endmodule
`default_nettype wire

// File: testbench/host_model.sv
// behavioural host bus master for the parallel port pins
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input wire logic clk,
   input wire logic bus_multiplex_select,
   input wire logic bus_style_select,
   input wire logic [7:0] ad_in,
   input wire logic ad_oe_n,
   output var pcp_pkg::host_pins_s pins
);
   initial pins = pcp_pkg::PINS_IDLE;
   // one transfer; q is 8'hEE when the port never drove the lines
   task automatic xfer(input logic cs, input logic rd, input logic [7:0] a,
      input logic [7:0] d, output logic [7:0] q);
      @(posedge clk);
      pins.cs_n <= ~cs;
      pins.ad <= bus_multiplex_select ? a : d;
      pins.ale <= bus_multiplex_select ? 1'b0 : a[7];
      pins.addr_lo <= bus_multiplex_select ? 7'h00 : a[6:0];
      // address sits on the lines before the latch rises
      if (bus_multiplex_select) begin
         @(posedge clk) pins.ale <= 1'b1;
         repeat (3) @(posedge clk);
         pins.ale <= 1'b0;
         pins.ad <= d;
         repeat (2) @(posedge clk);
      end
      @(posedge clk);
      pins.rd_n <= ~(bus_style_select | rd);
      pins.wr_n <= rd;
      // a released bus shows the inverse, never a stale value
      if (rd) pins.ad <= ~pins.ad;
      for (int n = 0; n < 12 && ad_oe_n !== 1'b0; n++) @(posedge clk);
      q = (ad_oe_n === 1'b0) ? ad_in : 8'hEE;
      pins.rd_n <= 1'b1;
      pins.wr_n <= 1'b1;
      repeat (3) @(posedge clk);
      pins <= pcp_pkg::PINS_IDLE;
      repeat (3) @(posedge clk);
   endtask
endmodule
`default_nettype wire

// File: testbench/test_parallel_control_port.sv
// self-checking bench for the parallel control port
`timescale 1ns/1ps
`default_nettype none
module test_parallel_control_port;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   pcp_pkg::straps_s straps = pcp_pkg::STRAPS_IDLE;
   pcp_pkg::host_pins_s pins;
   logic [7:0] ad_o, q;
   logic ad_oe_n, int_o, int_oe_n, trst_n_o, legacy_o, ack;
   logic [4:0] evt = 5'h00;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat, r;
   int err_count = 0;
   int checks_done = 0;
   // rows: mux, bus style, host address, data
   logic [17:0] rows [4] = '{{2'b00, 8'h85, 8'h3C}, {2'b01, 8'h12, 8'hA5},
      {2'b10, 8'hC3, 8'h5A}, {2'b11, 8'h7E, 8'h81}};
   always #10 sys_clk = ~sys_clk;
   parallel_control_port dut_u (.SYS_CLK(sys_clk), .RST_B(rst_b), .HOST_PINS_I(pins),
      .STRAPS_I(straps), .AD_O(ad_o), .AD_OE_N(ad_oe_n), .HOST_INT_O(int_o),
      .HOST_INT_OE_N(int_oe_n), .TEST_RST_N_O(trst_n_o), .LEGACY_MODE_O(legacy_o),
      .EVENT_I(evt), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
      .WB_SEL_I(4'h1), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack));
   host_model host_u (.clk(sys_clk), .bus_multiplex_select(straps.bus_multiplex_select),
      .bus_style_select(straps.bus_style_select), .ad_in(ad_o),
      .ad_oe_n(ad_oe_n), .pins(pins));
   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // classic single cycle, held until ack is seen high
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q32);
      @(posedge sys_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge sys_clk); while (ack !== 1'b1);
      q32 = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic close_out;
      if (err_count == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // watchdog sized well above the whole sequence
   initial begin
      repeat (20000) @(posedge sys_clk);
      err_count++;
      close_out();
   end
   initial begin
      repeat (6) @(posedge sys_clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge sys_clk);
      wb(1'b0, pcp_pkg::OFS_CTRL, 32'h0, r);
      chk_reg(r, 32'h1);
      foreach (rows[i]) begin
         straps.bus_multiplex_select <= rows[i][17];
         straps.bus_style_select <= rows[i][16];
         repeat (4) @(posedge sys_clk);
         host_u.xfer(1'b1, 1'b0, rows[i][15:8], rows[i][7:0], q);
         host_u.xfer(1'b1, 1'b1, rows[i][15:8], 8'h00, q);
         chk_pin(q, rows[i][7:0]);
         wb(1'b0, pcp_pkg::OFS_STATE, 32'h0, r);
         chk_reg(r, {16'h0, rows[i][15:8], 3'h0, rows[i][17:16], 3'b001});
         wb(1'b0, pcp_pkg::OFS_STATUS, 32'h0, r);
         chk_reg(r, {29'h0, rows[i][17], 2'b11});
         wb(1'b1, pcp_pkg::OFS_STATUS, 32'hFF, r);
      end
      // first row's register seen through the last mode
      host_u.xfer(1'b1, 1'b1, 8'h85, 8'h00, q);
      chk_pin(q, 8'h3C);
      host_u.xfer(1'b0, 1'b0, 8'h85, 8'h99, q);
      host_u.xfer(1'b0, 1'b1, 8'h85, 8'h00, q);
      chk_pin(q, 8'hEE);
      host_u.xfer(1'b1, 1'b1, 8'h85, 8'h00, q);
      chk_pin(q, 8'h3C);
      // port enable cleared: a selected read must not be answered
      wb(1'b1, pcp_pkg::OFS_CTRL, 32'h0, r);
      wb(1'b0, pcp_pkg::OFS_CTRL, 32'h0, r);
      chk_reg(r, 32'h0);
      host_u.xfer(1'b1, 1'b1, 8'h85, 8'h00, q);
      chk_pin(q, 8'hEE);
      wb(1'b1, pcp_pkg::OFS_CTRL, 32'h1, r);
      straps.float_all <= 1'b1;
      host_u.xfer(1'b1, 1'b1, 8'h85, 8'h00, q);
      chk_pin(q, 8'hEE);
      straps.float_all <= 1'b0;
      straps.legacy <= 1'b1;
      repeat (5) @(posedge sys_clk);
      chk_pin({6'h0, trst_n_o, legacy_o}, 8'h01);
      straps.legacy <= 1'b0;
      repeat (5) @(posedge sys_clk);
      chk_pin({6'h0, trst_n_o, legacy_o}, 8'h02);
      // event while masked, then unmasked, then cleared
      evt <= 5'h04;
      @(posedge sys_clk) evt <= 5'h00;
      repeat (3) @(posedge sys_clk);
      chk_pin({6'h0, int_o, int_oe_n}, 8'h01);
      wb(1'b1, pcp_pkg::OFS_MASK, 32'h20, r);
      repeat (3) @(posedge sys_clk);
      chk_pin({6'h0, int_o, int_oe_n}, 8'h00);
      wb(1'b1, pcp_pkg::OFS_STATUS, 32'h20, r);
      repeat (3) @(posedge sys_clk);
      chk_pin({6'h0, int_o, int_oe_n}, 8'h01);
      wb(1'b1, 8'h10, 32'hFF, r);
      wb(1'b0, 8'h10, 32'h0, r);
      chk_reg(r, 32'h0);
      rst_b <= 1'b0;
      repeat (6) @(posedge sys_clk);
      chk_pin({5'h0, ad_oe_n, int_oe_n, trst_n_o}, 8'h06);
      rst_b <= 1'b1;
      repeat (3) @(posedge sys_clk);
      wb(1'b0, pcp_pkg::OFS_MASK, 32'h0, r);
      chk_reg(r, 32'h0);
      wb(1'b0, pcp_pkg::OFS_STATUS, 32'h0, r);
      chk_reg(r, 32'h0);
      close_out();
   end
endmodule
`default_nettype wire
